// File: inc/pdph_pkg.sv
// Package with constants and carrier types for the PCI data-phase handshake
package pdph_pkg;
  // Bus cycle figures
  localparam int PDPH_STOP_END_MAX = 3;
  localparam int PDPH_DEVSEL_LAST = 4;
  localparam int PDPH_CNT_W = 3;
  localparam logic [PDPH_CNT_W-1:0] PDPH_CNT_ZERO = 3'h0;
  localparam logic [PDPH_CNT_W-1:0] PDPH_CNT_ONE = 3'h1;
  localparam logic [PDPH_CNT_W-1:0] PDPH_STOP_END_CNT =
    PDPH_CNT_W'(PDPH_STOP_END_MAX);
  localparam logic [PDPH_CNT_W-1:0] PDPH_DEVSEL_CNT =
    PDPH_CNT_W'(PDPH_DEVSEL_LAST);
  // Bus commands
  localparam logic [3:0] PDPH_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PDPH_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PDPH_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PDPH_CMD_RD_MULT = 4'hC;
  localparam logic [3:0] PDPH_CMD_RD_LINE = 4'hE;
  localparam logic [3:0] PDPH_CMD_WR_INV = 4'hF;
  // Cache line: offset bits and dword index field
  localparam int PDPH_LINE_LSB = 2;
  localparam int PDPH_LINE_MSB = 3;
  localparam logic [1:0] PDPH_LINE_LAST = 2'h3;
  localparam logic [31:0] PDPH_DATA_ZERO = 32'h0000_0000;

  // Sampled bus pins, all handshake lines active low
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic lock_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } pdph_bus_t;

  // Master side request from the core
  typedef struct packed {
    logic start;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic last;
    logic wr_valid;
    logic [31:0] wr_data;
    logic rd_ready;
  } pdph_mreq_t;

  // Target side request from the core
  typedef struct packed {
    logic wbuf_full;
    logic wbuf_pending;
    logic rd_valid;
    logic [31:0] rd_data;
    logic wr_ready;
    logic line_stop_en;
  } pdph_treq_t;
endpackage

// File: rtl/pdph_xfer.sv
`timescale 1ns/100ps
// Data-phase completion detector shared by master and target ends
module pdph_xfer
  import pdph_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic active,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic frame_n,
  output logic done,
  output logic last_done,
  output logic [7:0] count
);
  // A phase ends only when both ready lines are sampled low together
  assign done = active && !irdy_n && !trdy_n;
  assign last_done = done && frame_n;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
    end else if (!active) begin
      count <= 8'h00;
    end else if (done) begin
      count <= count + 8'h01;
    end
  end

  a_wait_no_count: assert property (@(posedge clk_sys) disable iff (reset)
    active && (irdy_n || trdy_n) |=> count == $past(count))
    else $error("count moved during a wait cycle");
endmodule

// File: rtl/pdph_core.sv
`timescale 1ns/100ps
// PCI data-phase handshake and stop logic, master and target ends
//
// Behaviour
// - A data phase ends only on an edge sampling both ready lines low.
// - Until both ready lines are low, wait cycles extend the phase.
// - Master raises initiator ready on writes only with valid write data, except in PDPH_M_STOP where it is always driven low.
// - On reads, master initiator ready means only ready to accept data, except in PDPH_M_STOP where it is always driven low.
// - Target raises target ready on reads only with valid read data.
// - On writes, target ready means only able to accept data.
// - Target asserts stop to end a transaction; devsel gives its kind.
// - As master, on stop drop frame and end within three clocks.
// - As target, stop when address phase shows frame and lock asserted.
// - As target, stop writes when buffers full or earlier cycle pending.
// - As target, stop reads crossing a cache line when enabled.
// - Frame deasserted marks the final data phase.
// - As master, abort if no devsel by subtractive clock, except special.
module pdph_core
  import pdph_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire pdph_bus_t bus_in,
  input wire pdph_mreq_t mreq,
  input wire pdph_treq_t treq,
  input wire logic tgt_sel,
  output logic frame_n_out,
  output logic frame_n_oe,
  output logic irdy_n_out,
  output logic irdy_n_oe,
  output logic trdy_n_out,
  output logic trdy_n_oe,
  output logic stop_n_out,
  output logic stop_n_oe,
  output logic devsel_n_out,
  output logic devsel_n_oe,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic [3:0] cbe_n_out,
  output logic cbe_n_oe,
  output logic m_busy,
  output logic m_data_done,
  output logic [31:0] m_rd_data,
  output logic m_stopped,
  output logic m_abort,
  output logic t_busy,
  output logic t_data_done,
  output logic [31:0] t_wr_data,
  output logic t_stopped
);
  typedef enum logic [2:0] {
    PDPH_M_IDLE, PDPH_M_ADDR, PDPH_M_DATA, PDPH_M_STOP, PDPH_M_TURN
  } pdph_mst_t;
  typedef enum logic [1:0] {
    PDPH_T_IDLE, PDPH_T_DATA, PDPH_T_STOP, PDPH_T_TURN
  } pdph_tst_t;

  function automatic logic cmd_is_read(input logic [3:0] c);
    cmd_is_read = (c == PDPH_CMD_MEM_RD) || (c == PDPH_CMD_RD_MULT) ||
      (c == PDPH_CMD_RD_LINE);
  endfunction

  pdph_mst_t mst_reg;
  pdph_tst_t tst_reg;
  logic [PDPH_CNT_W-1:0] mcnt_reg;
  logic m_read_reg;
  logic m_special_reg;
  logic m_devsel_seen_reg;
  logic t_read_reg;
  logic [1:0] t_line_reg;
  logic t_line_en_reg;
  logic m_done;
  logic t_done;
  logic t_stop_cond;
  logic m_irdy;
  logic t_trdy;

  // Both ends judge completion from the sampled pins
  pdph_xfer u_mxfer (
    .clk_sys(clk_sys),
    .reset(reset),
    .active(mst_reg == PDPH_M_DATA || mst_reg == PDPH_M_STOP),
    .irdy_n(bus_in.irdy_n),
    .trdy_n(bus_in.trdy_n),
    .frame_n(bus_in.frame_n),
    .done(m_done),
    .last_done(),
    .count()
  );
  pdph_xfer u_txfer (
    .clk_sys(clk_sys),
    .reset(reset),
    .active(tst_reg == PDPH_T_DATA),
    .irdy_n(bus_in.irdy_n),
    .trdy_n(bus_in.trdy_n),
    .frame_n(bus_in.frame_n),
    .done(t_done),
    .last_done(),
    .count()
  );

  // Master initiator ready: write needs data, read needs room
  assign m_irdy = m_read_reg ? mreq.rd_ready : mreq.wr_valid;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mst_reg <= PDPH_M_IDLE;
      mcnt_reg <= PDPH_CNT_ZERO;
      m_read_reg <= 1'b0;
      m_special_reg <= 1'b0;
      m_devsel_seen_reg <= 1'b0;
      m_stopped <= 1'b0;
      m_abort <= 1'b0;
    end else begin
      m_stopped <= 1'b0;
      m_abort <= 1'b0;
      case (mst_reg)
        PDPH_M_IDLE: begin
          if (mreq.start) begin
            mst_reg <= PDPH_M_ADDR;
            m_read_reg <= cmd_is_read(mreq.cmd);
            m_special_reg <= (mreq.cmd == PDPH_CMD_SPECIAL);
          end
        end
        PDPH_M_ADDR: begin
          mst_reg <= PDPH_M_DATA;
          mcnt_reg <= PDPH_CNT_ZERO;
          m_devsel_seen_reg <= 1'b0;
        end
        PDPH_M_DATA: begin
          mcnt_reg <= mcnt_reg + PDPH_CNT_ONE;
          if (!bus_in.devsel_n) begin
            m_devsel_seen_reg <= 1'b1;
          end
          if (!bus_in.stop_n) begin
            mst_reg <= PDPH_M_STOP;
            mcnt_reg <= PDPH_CNT_ONE;
          end else if (m_done && frame_n_out) begin
            mst_reg <= PDPH_M_TURN;
          end else if (!m_devsel_seen_reg && bus_in.devsel_n &&
                       mcnt_reg == PDPH_DEVSEL_CNT) begin
            // Special cycles never get a devsel and end normally
            if (!m_special_reg) begin
              m_abort <= 1'b1;
            end
            mst_reg <= PDPH_M_TURN;
          end
        end
        PDPH_M_STOP: begin
          mcnt_reg <= mcnt_reg + PDPH_CNT_ONE;
          // Ends at the latest on the second clock after the stop sample
          if (m_done || mcnt_reg >= PDPH_STOP_END_CNT - PDPH_CNT_ONE) begin
            mst_reg <= PDPH_M_TURN;
            m_stopped <= 1'b1;
          end
        end
        PDPH_M_TURN: mst_reg <= PDPH_M_IDLE;
        default: mst_reg <= PDPH_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      m_rd_data <= PDPH_DATA_ZERO;
      m_data_done <= 1'b0;
    end else begin
      m_data_done <= m_done;
      if (m_done && m_read_reg) begin
        m_rd_data <= bus_in.ad;
      end
    end
  end

  // Target stop causes, evaluated per data phase; PDPH_T_IDLE checks the address phase itself
  always_comb begin
    t_stop_cond = 1'b0;
    if (t_read_reg) begin
      t_stop_cond = t_line_en_reg && t_done &&
        t_line_reg == PDPH_LINE_LAST && !bus_in.frame_n;
    end else begin
      t_stop_cond = treq.wbuf_full || treq.wbuf_pending;
    end
  end

  assign t_trdy = t_read_reg ? treq.rd_valid : treq.wr_ready;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tst_reg <= PDPH_T_IDLE;
      t_read_reg <= 1'b0;
      t_line_reg <= 2'h0;
      t_line_en_reg <= 1'b0;
      t_stopped <= 1'b0;
    end else begin
      t_stopped <= 1'b0;
      case (tst_reg)
        PDPH_T_IDLE: begin
          // Address phase: frame asserted while idle
          if (!bus_in.frame_n && tgt_sel && mst_reg == PDPH_M_IDLE) begin
            t_read_reg <= cmd_is_read(bus_in.cbe_n);
            t_line_reg <= bus_in.ad[PDPH_LINE_MSB:PDPH_LINE_LSB];
            t_line_en_reg <= treq.line_stop_en;
            if (!bus_in.lock_n) begin
              tst_reg <= PDPH_T_STOP;
            end else if (!cmd_is_read(bus_in.cbe_n) &&
                         (treq.wbuf_full || treq.wbuf_pending)) begin
              tst_reg <= PDPH_T_STOP;
            end else begin
              tst_reg <= PDPH_T_DATA;
            end
          end
        end
        PDPH_T_DATA: begin
          if (t_done) begin
            t_line_reg <= t_line_reg + 2'h1;
          end
          if (t_done && bus_in.frame_n) begin
            tst_reg <= PDPH_T_TURN;
          end else if (t_stop_cond && (t_read_reg || !t_done)) begin
            tst_reg <= PDPH_T_STOP;
          end
        end
        PDPH_T_STOP: begin
          // Stop held until master drops frame
          if (bus_in.frame_n) begin
            tst_reg <= PDPH_T_TURN;
            t_stopped <= 1'b1;
          end
        end
        PDPH_T_TURN: tst_reg <= PDPH_T_IDLE;
        default: tst_reg <= PDPH_T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      t_wr_data <= PDPH_DATA_ZERO;
      t_data_done <= 1'b0;
    end else begin
      t_data_done <= t_done;
      if (t_done && !t_read_reg) begin
        t_wr_data <= bus_in.ad;
      end
    end
  end

  // Pin drive; all handshake lines are active low
  always_comb begin
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
    ad_out = PDPH_DATA_ZERO;
    cbe_n_out = 4'hF;
    case (mst_reg)
      PDPH_M_ADDR: begin
        frame_n_out = 1'b0;
        ad_out = mreq.addr;
        cbe_n_out = mreq.cmd;
      end
      PDPH_M_DATA: begin
        frame_n_out = mreq.last && m_irdy;
        irdy_n_out = !m_irdy;
        ad_out = mreq.wr_data;
        cbe_n_out = 4'h0;
      end
      PDPH_M_STOP: begin
        frame_n_out = 1'b1;
        irdy_n_out = 1'b0;
        ad_out = mreq.wr_data;
        cbe_n_out = 4'h0;
      end
      default: begin
        frame_n_out = 1'b1;
      end
    endcase
    if (tst_reg == PDPH_T_DATA && t_read_reg) begin
      ad_out = treq.rd_data;
    end
  end

  assign frame_n_oe = mst_reg != PDPH_M_IDLE;
  assign irdy_n_oe = mst_reg != PDPH_M_IDLE && mst_reg != PDPH_M_ADDR;
  assign cbe_n_oe = (irdy_n_oe && mst_reg != PDPH_M_TURN) ||
    mst_reg == PDPH_M_ADDR;
  assign ad_oe = (mst_reg == PDPH_M_ADDR) ||
    ((mst_reg == PDPH_M_DATA || mst_reg == PDPH_M_STOP) && !m_read_reg) ||
    (tst_reg == PDPH_T_DATA && t_read_reg);
  // Line stop follows the completing read, so it cannot gate trdy
  assign trdy_n_out = !(tst_reg == PDPH_T_DATA && t_trdy &&
    (t_read_reg || !(treq.wbuf_full || treq.wbuf_pending)));
  assign stop_n_out = tst_reg != PDPH_T_STOP;
  assign devsel_n_out = !(tst_reg == PDPH_T_DATA || tst_reg == PDPH_T_STOP);
  assign trdy_n_oe = tst_reg != PDPH_T_IDLE;
  assign stop_n_oe = tst_reg != PDPH_T_IDLE;
  assign devsel_n_oe = tst_reg != PDPH_T_IDLE;
  assign m_busy = mst_reg != PDPH_M_IDLE;
  assign t_busy = tst_reg != PDPH_T_IDLE;

  a_stop_frame_end: assert property (@(posedge clk_sys) disable iff (reset)
    mst_reg == PDPH_M_DATA && !bus_in.stop_n |=> ##[0:2]
    mst_reg == PDPH_M_TURN)
    else $error("master did not end within three clocks of stop");
  a_stop_frame_high: assert property (@(posedge clk_sys) disable iff (reset)
    mst_reg == PDPH_M_STOP |-> frame_n_out)
    else $error("frame driven low after stop");
  a_wr_irdy_data: assert property (@(posedge clk_sys) disable iff (reset)
    mst_reg == PDPH_M_DATA && !m_read_reg && !irdy_n_out |->
    mreq.wr_valid && ad_oe)
    else $error("initiator ready without write data");
  a_rd_trdy_data: assert property (@(posedge clk_sys) disable iff (reset)
    !trdy_n_out && t_read_reg |-> treq.rd_valid && ad_oe)
    else $error("target ready without read data");
  a_lock_stop: assert property (@(posedge clk_sys) disable iff (reset)
    tst_reg == PDPH_T_IDLE && tgt_sel && mst_reg == PDPH_M_IDLE &&
    !bus_in.frame_n && !bus_in.lock_n |=> !stop_n_out)
    else $error("no stop on locked access");
  a_wbuf_stop: assert property (@(posedge clk_sys) disable iff (reset)
    tst_reg == PDPH_T_IDLE && tgt_sel && mst_reg == PDPH_M_IDLE &&
    !bus_in.frame_n && !cmd_is_read(bus_in.cbe_n) && treq.wbuf_full
    |=> !stop_n_out)
    else $error("no stop on full write buffers");
  a_line_stop: assert property (@(posedge clk_sys) disable iff (reset)
    tst_reg == PDPH_T_DATA && t_read_reg && !t_line_en_reg
    |=> stop_n_out)
    else $error("line stop while disabled");
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    m_done |=> m_data_done)
    else $error("completed phase not reported");
  a_master_abort: assert property (@(posedge clk_sys) disable iff (reset)
    m_abort |-> !m_special_reg && !m_devsel_seen_reg)
    else $error("abort with devsel or on special cycle");
endmodule

// File: verif/pdph_far.sv
`timescale 1ns/100ps
// Far-side agent: target for the core's master, master for its target
module pdph_far
  import pdph_pkg::*;
(
  input wire logic clk_sys,
  input wire pdph_bus_t bus,
  input wire logic [1:0] t_mode,
  input wire logic [1:0] t_wait,
  input wire logic [31:0] t_rdata,
  output pdph_bus_t drv,
  output pdph_bus_t oe,
  output logic [31:0] got
);
  logic act, mst, wr, fs, is, ts, ss;
  logic [31:0] a;
  int wc;
  initial begin
    drv = '1;
    oe = '0;
    act = 1'b0;
    mst = 1'b0;
  end
  // Mode 0 never claims, 1 answers, 2 claims and stops with no data
  always @(posedge clk_sys) begin
    fs = bus.frame_n;
    is = bus.irdy_n;
    ts = bus.trdy_n;
    ss = bus.stop_n;
    a = bus.ad;
    wr = act ? wr : bus.cbe_n[0];
    #1;
    if (!act && !mst && !fs && t_mode != 2'h0) begin
      act = 1'b1;
      wc = t_wait;
      oe.devsel_n = 1'b1;
      oe.trdy_n = 1'b1;
      oe.stop_n = 1'b1;
      drv.devsel_n = 1'b0;
      drv.stop_n = t_mode != 2'h2;
    end else if (act) begin
      if (wr && !is && !ts) got = a;
      if (fs && (!ss || (!is && !ts))) begin
        act = 1'b0;
        oe = '0;
        drv = '1;
      end else if (t_mode == 2'h1 && wc == 0) begin
        drv.trdy_n = 1'b0;
        drv.ad = t_rdata;
        oe.ad = {32{!wr}};
      end else if (wc > 0) begin
        wc--;
      end
    end
  end
  // One transaction as master; reads keep the last completed dword
  task automatic mxfer(input logic [3:0] cmd, input logic [31:0] ad,
                       input logic [31:0] d, input int nph, input logic lk);
    int n, k;
    mst = 1'b1;
    @(posedge clk_sys);
    #1;
    drv.frame_n = 1'b0;
    oe.frame_n = 1'b1;
    drv.lock_n = !lk;
    oe.lock_n = 1'b1;
    drv.cbe_n = cmd;
    oe.cbe_n = '1;
    drv.ad = ad;
    oe.ad = '1;
    @(posedge clk_sys);
    for (k = 0; k < nph; k++) begin
      #1;
      drv.frame_n = k == nph - 1;
      drv.irdy_n = 1'b0;
      oe.irdy_n = 1'b1;
      drv.lock_n = 1'b1;
      drv.cbe_n = 4'h0;
      drv.ad = d + k;
      oe.ad = {32{cmd[0]}};
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (bus.trdy_n && bus.stop_n && n < 16);
      if (!bus.trdy_n && !cmd[0]) got = bus.ad;
      if (!bus.stop_n) k = nph;
    end
    #1;
    oe = '0;
    drv = '1;
    mst = 1'b0;
  endtask
endmodule

// File: verif/pdph_core_test.sv
`timescale 1ns/100ps
// Self-checking bench for the data-phase handshake and stop logic
module pdph_core_test
  import pdph_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pdph_bus_t bus, fdrv, foe;
  pdph_mreq_t mreq = '0;
  pdph_treq_t treq = '0;
  logic tgt_sel = 1'b0;
  logic frame_n_out, frame_n_oe, irdy_n_out, irdy_n_oe, trdy_n_out;
  logic trdy_n_oe, stop_n_out, stop_n_oe, devsel_n_out, devsel_n_oe;
  logic ad_oe, cbe_n_oe, m_busy, m_data_done, m_stopped, m_abort;
  logic t_busy, t_data_done, t_stopped;
  logic [3:0] cbe_n_out;
  logic [31:0] ad_out, m_rd_data, t_wr_data, got;
  logic [31:0] t_rdata = 32'h0, ad_last = 32'h0;
  logic [1:0] t_mode = 2'h0, t_wait = 2'h0;
  int cnt [8];
  int fails = 0, n_checks = 0, cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Pull-ups on handshake lines; undriven data lines flip every cycle
  always_comb begin
    bus.frame_n = frame_n_oe ? frame_n_out : !foe.frame_n | fdrv.frame_n;
    bus.irdy_n = irdy_n_oe ? irdy_n_out : !foe.irdy_n | fdrv.irdy_n;
    bus.trdy_n = trdy_n_oe ? trdy_n_out : !foe.trdy_n | fdrv.trdy_n;
    bus.stop_n = stop_n_oe ? stop_n_out : !foe.stop_n | fdrv.stop_n;
    bus.devsel_n = devsel_n_oe ? devsel_n_out : !foe.devsel_n | fdrv.devsel_n;
    bus.lock_n = !foe.lock_n | fdrv.lock_n;
    bus.cbe_n = cbe_n_oe ? cbe_n_out :
      foe.cbe_n[0] ? fdrv.cbe_n : ~ad_last[3:0];
    bus.ad = ad_oe ? ad_out : foe.ad[0] ? fdrv.ad : ~ad_last;
  end
  pdph_core dut (.clk_sys(clk_sys), .reset(reset), .bus_in(bus),
    .mreq(mreq), .treq(treq), .tgt_sel(tgt_sel),
    .frame_n_out(frame_n_out), .frame_n_oe(frame_n_oe),
    .irdy_n_out(irdy_n_out), .irdy_n_oe(irdy_n_oe),
    .trdy_n_out(trdy_n_out), .trdy_n_oe(trdy_n_oe),
    .stop_n_out(stop_n_out), .stop_n_oe(stop_n_oe),
    .devsel_n_out(devsel_n_out), .devsel_n_oe(devsel_n_oe),
    .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_out(cbe_n_out),
    .cbe_n_oe(cbe_n_oe), .m_busy(m_busy), .m_data_done(m_data_done),
    .m_rd_data(m_rd_data), .m_stopped(m_stopped), .m_abort(m_abort),
    .t_busy(t_busy), .t_data_done(t_data_done), .t_wr_data(t_wr_data),
    .t_stopped(t_stopped));
  pdph_far far (.clk_sys(clk_sys), .bus(bus), .t_mode(t_mode),
    .t_wait(t_wait), .t_rdata(t_rdata), .drv(fdrv), .oe(foe), .got(got));
  // Pulse and bus-event counters, cleared by each scenario
  always @(posedge clk_sys) begin
    ad_last <= bus.ad;
    cnt[0] += m_data_done;
    cnt[1] += m_stopped;
    cnt[2] += m_abort;
    cnt[3] += t_data_done;
    cnt[4] += t_stopped;
    cnt[5] += !bus.irdy_n && !bus.trdy_n;
    cnt[6] += !bus.stop_n && !bus.frame_n && frame_n_oe;
    cnt[7] += !bus.devsel_n && devsel_n_oe;
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  task automatic m_op(input logic [3:0] cmd, input logic lst,
                      input logic [1:0] md);
    int n;
    t_mode = md;
    cnt = '{default: 0};
    mreq.cmd = cmd;
    mreq.last = lst;
    mreq.start = 1'b1;
    @(posedge clk_sys);
    #1;
    mreq.start = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (m_busy !== 1'b0 && n < 40);
    check("m idle", m_busy, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_op(input logic [3:0] cmd, input logic [31:0] ad,
                      input int nph, input logic lk, input logic [2:0] cf);
    cnt = '{default: 0};
    treq.wbuf_full = cf[2];
    treq.wbuf_pending = cf[1];
    treq.line_stop_en = cf[0];
    far.mxfer(cmd, ad, 32'h0000_BEE0, nph, lk);
    repeat (3) @(posedge clk_sys);
    #1;
    check("t idle", t_busy, 1'b0);
    check("devsel", cnt[7] > 0, 1'b1);
  endtask
  task automatic t_master();
    logic [3:0] rc [3] = '{PDPH_CMD_MEM_RD, PDPH_CMD_RD_MULT,
      PDPH_CMD_RD_LINE};
    t_wait = 2'h2;
    mreq.wr_data = 32'hA5C3_0F01;
    m_op(PDPH_CMD_MEM_WR, 1'b1, 2'h1);
    check("write data", got, 32'hA5C3_0F01);
    check("write done", cnt[0], 1);
    check("write phases", cnt[5], 1);
    for (int i = 0; i < 3; i++) begin
      t_rdata = 32'h5A00_0010 + i;
      m_op(rc[i], 1'b1, 2'h1);
      check("read data", m_rd_data, 32'h5A00_0010 + i);
      check("read done", cnt[0], 1);
    end
    $display("test master transfers done");
  endtask
  task automatic t_stop_abort();
    m_op(PDPH_CMD_MEM_WR, 1'b0, 2'h2);
    check("m_stopped", cnt[1], 1);
    check("stop no data", cnt[0], 0);
    check("frame end", cnt[6] <= 3, 1);
    m_op(PDPH_CMD_MEM_RD, 1'b1, 2'h0);
    check("m_abort", cnt[2], 1);
    m_op(PDPH_CMD_SPECIAL, 1'b1, 2'h0);
    check("special", cnt[2], 0);
    $display("test stop and abort done");
  endtask
  task automatic t_target();
    for (int i = 0; i < 3; i++) begin
      t_op(PDPH_CMD_MEM_WR, 32'h0000_2000, 1, 1'b0, {i == 0, i == 1, 1'b0});
      check("write stop", cnt[4], i != 2);
      check("write done", cnt[3], i == 2);
    end
    check("write data", t_wr_data, 32'h0000_BEE0);
    treq.rd_data = 32'h3C3C_0007;
    t_op(PDPH_CMD_MEM_RD, 32'h0000_3000, 1, 1'b1, 3'h0);
    check("lock stop", cnt[4], 1);
    t_op(PDPH_CMD_MEM_RD, 32'h0000_300C, 2, 1'b0, 3'h1);
    check("line stop", cnt[4], 1);
    check("line done", cnt[3], 1);
    t_op(PDPH_CMD_MEM_RD, 32'h0000_300C, 2, 1'b0, 3'h0);
    check("no line stop", cnt[4], 0);
    check("read data", got, 32'h3C3C_0007);
    $display("test target transfers done");
  endtask
  initial begin
    mreq.wr_valid = 1'b1;
    mreq.rd_ready = 1'b1;
    mreq.addr = 32'h0000_1000;
    treq.rd_valid = 1'b1;
    treq.wr_ready = 1'b1;
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_master();
    t_stop_abort();
    tgt_sel = 1'b1;
    t_target();
    summarize();
  end
endmodule
